// [logic/rmwr_pkg.sv]
// Package of constants for the register map and wait/request block.
// Functional notes
// - Enable low holds pin inactive: high or floating.
// - Enable high drives pin as wait or request.
// - Wait drives low on early CPU transfer.
// - Request drives low when ready to transfer.
// - Transmit select follows transmit buffer state.
// - Separate transmit request on terminal-ready pin.
// - Channel bit plus pointer selects; vector shared.
// - No status FIFO: indices 4-7 alias 0-3.
// - Extended read, with the status FIFO also on, returns selected write registers.
// - Point high selects registers 8 to 15.
// - Master interrupt control shared by both channels.
// - Receive select follows receive buffer state.
// - Request appears only while device not selected, except the CRC end pulse.
// - CRC end pulses request low one cycle.
// - Point high and pointer come in one write.
package rmwr_pkg;
  localparam int DATA_W = 8;
  localparam int IDX_W = 4;
  localparam int PTR_W = 3;
  localparam int CHAN_N = 2;
  localparam int REG_N = 16;

  localparam logic [IDX_W-1:0] IDX_CMD = 4'h0;
  localparam logic [IDX_W-1:0] IDX_MODE = 4'h1;
  localparam logic [IDX_W-1:0] IDX_VEC = 4'h2;
  localparam logic [IDX_W-1:0] IDX_RXCTL = 4'h3;
  localparam logic [IDX_W-1:0] IDX_LOW4 = 4'h4;
  localparam logic [IDX_W-1:0] IDX_LOW5 = 4'h5;
  localparam logic [IDX_W-1:0] IDX_FRAME_LO = 4'h6;
  localparam logic [IDX_W-1:0] IDX_FRAME_HI = 4'h7;
  localparam logic [IDX_W-1:0] IDX_DATA = 4'h8;
  localparam logic [IDX_W-1:0] IDX_MIC = 4'h9;
  localparam logic [IDX_W-1:0] IDX_MISC10 = 4'hA;
  localparam logic [IDX_W-1:0] IDX_HI11 = 4'hB;
  localparam logic [IDX_W-1:0] IDX_HI13 = 4'hD;
  localparam logic [IDX_W-1:0] IDX_HI14 = 4'hE;
  localparam logic [IDX_W-1:0] IDX_STAT_EN = 4'hF;
  localparam logic [IDX_W-1:0] IDX_ALIAS_OFS = 4'h4;

  localparam int MODE_WREQ_EN = 7;
  localparam int MODE_FUNC_REQ = 6;
  localparam int MODE_RX_SEL = 5;
  localparam int CMD_CODE_LSB = 3;
  localparam int CRC_CODE_LSB = 6;
  localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
  localparam int STAT_FIFO_BIT = 2;
  localparam int STAT_PRIME_BIT = 0;
  localparam int ENH_EXT_READ = 6;
  localparam int DTR_REQ_BIT = 2;

  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [PTR_W-1:0] RST_PTR = 3'h0;
endpackage : rmwr_pkg

// [logic/rmwr_top.sv]
// Register address decode and wait/request control for a two-channel serial controller.
module rmwr_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cs,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic chan_sel,
  input wire logic [rmwr_pkg::DATA_W-1:0] din,
  input wire logic [1:0][15:0][rmwr_pkg::DATA_W-1:0] rr_image,
  input wire logic [1:0] tx_full,
  input wire logic [1:0] rx_avail,
  input wire logic [1:0] sync_mode,
  input wire logic [1:0] crc_end,
  output logic [rmwr_pkg::DATA_W-1:0] dout,
  output logic cmd_stb,
  output logic [2:0] cmd_code,
  output logic [1:0] crc_code,
  output logic cmd_chan,
  output logic [rmwr_pkg::DATA_W-1:0] tx_data,
  output logic [1:0] tx_load,
  output logic [1:0] rx_take,
  output logic [rmwr_pkg::DATA_W-1:0] irq_vector,
  output logic [rmwr_pkg::DATA_W-1:0] master_irq_ctl,
  output logic [1:0] wreq_o,
  output logic [1:0] wreq_oe,
  output logic [1:0] dtr_req_o
);
  import rmwr_pkg::*;

  // ----------------------------------------------------------------
  // Register storage and access tracking
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] wr_reg [0:CHAN_N-1][0:REG_N-1];
  logic [DATA_W-1:0] wr_next [0:CHAN_N-1][0:REG_N-1];
  logic [DATA_W-1:0] enh_reg [0:CHAN_N-1];
  logic [DATA_W-1:0] enh_next [0:CHAN_N-1];
  logic [DATA_W-1:0] vec_reg, vec_next;
  logic [DATA_W-1:0] mic_reg, mic_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next;
  logic ph_reg, ph_next;
  logic busy_reg, busy_next;
  logic [IDX_W-1:0] cur_idx_reg, cur_idx_next;
  logic cur_chan_reg, cur_chan_next;
  logic cur_wr_reg, cur_wr_next;
  logic [DATA_W-1:0] wdat_reg, wdat_next;
  logic [DATA_W-1:0] dout_next;
  logic cmd_stb_next;
  logic [2:0] cmd_code_next;
  logic [1:0] crc_code_next;
  logic cmd_chan_next;
  logic [DATA_W-1:0] tx_data_next;
  logic [1:0] tx_load_next;
  logic [1:0] rx_take_next;

  logic in_cyc;
  logic start;
  logic finish;
  logic [IDX_W-1:0] acc_idx;
  logic acc_chan;
  logic fifo_on;
  logic ext_on;
  logic [DATA_W-1:0] alias_img;
  logic [DATA_W-1:0] rd_val;

  // ----------------------------------------------------------------
  // Access phase
  // ----------------------------------------------------------------
  // All write side effects and the pointer update happen when the bus
  // cycle ends, so a write held off by the wait pin lands with final data.
  assign in_cyc = cs && (rd_en || wr_en);
  assign start = in_cyc && !busy_reg;
  assign finish = !in_cyc && busy_reg;
  assign acc_idx = start ? {ph_reg, ptr_reg} : cur_idx_reg;
  assign acc_chan = start ? chan_sel : cur_chan_reg;

  // ----------------------------------------------------------------
  // Read image selection
  // ----------------------------------------------------------------
  always_comb begin
    fifo_on = wr_reg[acc_chan][IDX_STAT_EN][STAT_FIFO_BIT];
    ext_on = fifo_on && enh_reg[acc_chan][ENH_EXT_READ];
    alias_img = rr_image[acc_chan][acc_idx - IDX_ALIAS_OFS];
    rd_val = rr_image[acc_chan][acc_idx];
    case (acc_idx)
      IDX_LOW4, IDX_LOW5: begin
        rd_val = ext_on ? wr_reg[acc_chan][acc_idx] : alias_img;
      end
      IDX_FRAME_LO, IDX_FRAME_HI: begin
        rd_val = fifo_on ? rr_image[acc_chan][acc_idx] : alias_img;
      end
      IDX_MIC: rd_val = ext_on ? wr_reg[acc_chan][IDX_RXCTL]
        : rr_image[acc_chan][IDX_HI13];
      IDX_HI11: rd_val = ext_on ? wr_reg[acc_chan][IDX_MISC10]
        : rr_image[acc_chan][IDX_STAT_EN];
      IDX_HI14: begin
        rd_val = ext_on ? enh_reg[acc_chan] : rr_image[acc_chan][IDX_HI14];
      end
      default: begin
        rd_val = rr_image[acc_chan][acc_idx];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    wr_next = wr_reg;
    enh_next = enh_reg;
    vec_next = vec_reg;
    mic_next = mic_reg;
    ptr_next = ptr_reg;
    ph_next = ph_reg;
    busy_next = in_cyc;
    cur_idx_next = cur_idx_reg;
    cur_chan_next = cur_chan_reg;
    cur_wr_next = cur_wr_reg;
    wdat_next = wdat_reg;
    dout_next = dout;
    cmd_stb_next = 1'b0;
    cmd_code_next = cmd_code;
    crc_code_next = crc_code;
    cmd_chan_next = cmd_chan;
    tx_data_next = tx_data;
    tx_load_next = 2'h0;
    rx_take_next = 2'h0;
    if (start) begin
      cur_idx_next = acc_idx;
      cur_chan_next = chan_sel;
      cur_wr_next = wr_en;
    end
    if (in_cyc && wr_en) begin
      wdat_next = din;
    end
    if (in_cyc && rd_en) begin
      dout_next = rd_val;
    end
    if (finish) begin
      if (cur_idx_reg != IDX_CMD) begin
        ptr_next = RST_PTR;
        ph_next = 1'b0;
      end
      if (cur_wr_reg) begin
        case (cur_idx_reg)
          IDX_CMD: begin
            // Pointer and point-high arrive together in one command write.
            ptr_next = wdat_reg[PTR_W-1:0];
            ph_next = (wdat_reg[CMD_CODE_LSB +: 3] == CMD_POINT_HIGH);
            cmd_stb_next = 1'b1;
            cmd_code_next = wdat_reg[CMD_CODE_LSB +: 3];
            crc_code_next = wdat_reg[CRC_CODE_LSB +: 2];
            cmd_chan_next = cur_chan_reg;
            wr_next[cur_chan_reg][IDX_CMD] = wdat_reg;
          end
          IDX_VEC: begin
            vec_next = wdat_reg;
          end
          IDX_MIC: begin
            mic_next = wdat_reg;
          end
          IDX_DATA: begin
            tx_data_next = wdat_reg;
            tx_load_next[cur_chan_reg] = 1'b1;
          end
          IDX_FRAME_HI: begin
            if (wr_reg[cur_chan_reg][IDX_STAT_EN][STAT_PRIME_BIT]) begin
              enh_next[cur_chan_reg] = wdat_reg;
            end else begin
              wr_next[cur_chan_reg][IDX_FRAME_HI] = wdat_reg;
            end
          end
          default: begin
            wr_next[cur_chan_reg][cur_idx_reg] = wdat_reg;
          end
        endcase
      end else if (cur_idx_reg == IDX_DATA) begin
        rx_take_next[cur_chan_reg] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int c = 0; c < CHAN_N; c++) begin
        for (int r = 0; r < REG_N; r++) begin
          wr_reg[c][r] <= RST_BYTE;
        end
        enh_reg[c] <= RST_BYTE;
      end
      vec_reg <= RST_BYTE;
      mic_reg <= RST_BYTE;
      ptr_reg <= RST_PTR;
      ph_reg <= 1'b0;
      busy_reg <= 1'b0;
      cur_idx_reg <= IDX_CMD;
      cur_chan_reg <= 1'b0;
      cur_wr_reg <= 1'b0;
      wdat_reg <= RST_BYTE;
      dout <= RST_BYTE;
      cmd_stb <= 1'b0;
      cmd_code <= 3'h0;
      crc_code <= 2'h0;
      cmd_chan <= 1'b0;
      tx_data <= RST_BYTE;
      tx_load <= 2'h0;
      rx_take <= 2'h0;
    end else begin
      wr_reg <= wr_next;
      enh_reg <= enh_next;
      vec_reg <= vec_next;
      mic_reg <= mic_next;
      ptr_reg <= ptr_next;
      ph_reg <= ph_next;
      busy_reg <= busy_next;
      cur_idx_reg <= cur_idx_next;
      cur_chan_reg <= cur_chan_next;
      cur_wr_reg <= cur_wr_next;
      wdat_reg <= wdat_next;
      dout <= dout_next;
      cmd_stb <= cmd_stb_next;
      cmd_code <= cmd_code_next;
      crc_code <= crc_code_next;
      cmd_chan <= cmd_chan_next;
      tx_data <= tx_data_next;
      tx_load <= tx_load_next;
      rx_take <= rx_take_next;
    end
  end

  assign irq_vector = vec_reg;
  assign master_irq_ctl = mic_reg;

  // ----------------------------------------------------------------
  // Wait/request pins, one controller per channel
  // ----------------------------------------------------------------
  for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
    rmwr_wreq u_wreq (
      .sys_clk(sys_clk),
      .srst(srst),
      .wreq_en(wr_reg[c][IDX_MODE][MODE_WREQ_EN]),
      .func_req(wr_reg[c][IDX_MODE][MODE_FUNC_REQ]),
      .rx_sel(wr_reg[c][IDX_MODE][MODE_RX_SEL]),
      .dtr_req_en(wr_reg[c][IDX_HI14][DTR_REQ_BIT]),
      .tx_full(tx_full[c]),
      .rx_avail(rx_avail[c]),
      .sync_mode(sync_mode[c]),
      .crc_end(crc_end[c]),
      .selected(cs),
      .cpu_rd_data(in_cyc && rd_en && (acc_chan == 1'(c)) && (acc_idx == IDX_DATA)),
      .cpu_wr_data(in_cyc && wr_en && (acc_chan == 1'(c)) && (acc_idx == IDX_DATA)),
      .pin_o(wreq_o[c]),
      .pin_oe(wreq_oe[c]),
      .dtr_o(dtr_req_o[c])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  wire logic [DATA_W-1:0] chk_img = rr_image[acc_chan][acc_idx];

  sequence s_cmd_write;
    finish && cur_wr_reg && (cur_idx_reg == IDX_CMD);
  endsequence

  a_ptr_return: assert property (finish && (cur_idx_reg != IDX_CMD)
    |=> (ptr_reg == RST_PTR) && !ph_reg)
    else $error("pointer did not return to zero");
  a_point_high: assert property (s_cmd_write
    ##0 (wdat_reg[CMD_CODE_LSB +: 3] == CMD_POINT_HIGH)
    |=> ph_reg && (ptr_reg == wdat_reg[PTR_W-1:0]))
    else $error("point high not applied with pointer");
  a_vec_shared: assert property (finish && cur_wr_reg && (cur_idx_reg == IDX_VEC)
    |=> irq_vector == $past(wdat_reg))
    else $error("shared vector not written");
  a_mic_shared: assert property (finish && cur_wr_reg && (cur_idx_reg == IDX_MIC)
    |=> master_irq_ctl == $past(wdat_reg))
    else $error("shared master control not written");
  a_alias_read: assert property (in_cyc && rd_en && !fifo_on
    && !acc_idx[3] && acc_idx[2] |=> dout == $past(alias_img))
    else $error("low group alias not returned");
  a_frame_read: assert property (in_cyc && rd_en && fifo_on && !ext_on
    && ((acc_idx == IDX_FRAME_LO) || (acc_idx == IDX_FRAME_HI))
    |=> dout == $past(chk_img))
    else $error("frame status read failed");
endmodule : rmwr_top

// [logic/rmwr_wreq.sv]
// Per-channel wait/request pin and transmit request pin control.
module rmwr_wreq (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wreq_en,
  input wire logic func_req,
  input wire logic rx_sel,
  input wire logic dtr_req_en,
  input wire logic tx_full,
  input wire logic rx_avail,
  input wire logic sync_mode,
  input wire logic crc_end,
  input wire logic selected,
  input wire logic cpu_rd_data,
  input wire logic cpu_wr_data,
  output logic pin_o,
  output logic pin_oe,
  output logic dtr_o
);
  import rmwr_pkg::*;

  logic pin_o_next;
  logic pin_oe_next;
  logic dtr_next;
  logic ready;
  logic stall;
  logic crc_hit;

  always_comb begin
    ready = rx_sel ? rx_avail : !tx_full;
    stall = rx_sel ? (cpu_rd_data && !rx_avail) : (cpu_wr_data && tx_full);
    crc_hit = !rx_sel && sync_mode && crc_end;
    if (!func_req) begin
      pin_o_next = 1'b0;
      pin_oe_next = wreq_en && stall;
    end else begin
      pin_oe_next = 1'b1;
      // Ready request is masked while chip select is high so it cannot race the access in progress; the CRC end pulse is not.
      pin_o_next = !(wreq_en && ((ready && !selected) || crc_hit));
    end
    dtr_next = !(dtr_req_en && !tx_full && !selected);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_o <= 1'b1;
      pin_oe <= 1'b0;
      dtr_o <= 1'b1;
    end else begin
      pin_o <= pin_o_next;
      pin_oe <= pin_oe_next;
      dtr_o <= dtr_next;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence s_crc_end;
    wreq_en && func_req && !rx_sel && sync_mode && crc_end && tx_full;
  endsequence
  sequence s_crc_after;
    wreq_en && func_req && !rx_sel && tx_full && !crc_end;
  endsequence

  a_wait_float: assert property (!wreq_en && !func_req |=> !pin_oe)
    else $error("wait pin driven while disabled");
  a_req_idle: assert property (!wreq_en && func_req |=> pin_oe && pin_o)
    else $error("request pin not high while disabled");
  a_req_drive: assert property (wreq_en && func_req |=> pin_oe)
    else $error("request pin not driven");
  a_wait_low: assert property (wreq_en && !func_req && stall |=> pin_oe && !pin_o)
    else $error("wait not asserted on early transfer");
  a_req_ready: assert property (wreq_en && func_req && ready && !selected |=> !pin_o)
    else $error("request not asserted when ready");
  a_tx_full_idle: assert property (wreq_en && func_req && !rx_sel && tx_full
    && !crc_end |=> pin_o)
    else $error("request asserted with full transmit buffer");
  a_rx_empty_idle: assert property (wreq_en && func_req && rx_sel && !rx_avail
    |=> pin_o)
    else $error("request asserted with empty receive buffer");
  a_req_selected: assert property (func_req && selected && !crc_hit |=> pin_o)
    else $error("request asserted while selected");
  a_crc_pulse: assert property (s_crc_end ##1 s_crc_after |-> !pin_o ##1 pin_o)
    else $error("crc request pulse not one cycle");
  a_dtr_req: assert property (dtr_req_en && !tx_full && !selected |=> !dtr_o)
    else $error("transmit request not asserted");
endmodule : rmwr_wreq

// [sim/rmwr_host.sv]
// Host bus model that runs register read and write cycles on the parallel bus.
module rmwr_host (
  input wire logic sys_clk,
  input wire logic [rmwr_pkg::DATA_W-1:0] dout,
  input wire logic [1:0] wreq_o,
  input wire logic [1:0] wreq_oe,
  output logic cs,
  output logic rd_en,
  output logic wr_en,
  output logic chan_sel,
  output logic [rmwr_pkg::DATA_W-1:0] din
);
  timeunit 1ns;
  timeprecision 1ns;
  import rmwr_pkg::*;

  initial begin
    cs = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    chan_sel = 1'b0;
    din = 8'h00;
  end

  // One transfer per call; the wait loop is bounded so a stuck pin cannot hang the bus.
  task automatic cyc(input logic ch, input logic wr, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] q);
    int n;
    @(negedge sys_clk);
    cs = 1'b1;
    rd_en = ~wr;
    wr_en = wr;
    chan_sel = ch;
    din = d;
    repeat (2) @(negedge sys_clk);
    n = 0;
    while (wreq_oe[ch] === 1'b1 && wreq_o[ch] === 1'b0 && n < 32) begin
      @(negedge sys_clk);
      n++;
    end
    q = dout;
    cs = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    // A released data bus shows the inverse of the last value, never a stale copy.
    din = ~d;
    repeat (2) @(negedge sys_clk);
  endtask : cyc
endmodule : rmwr_host

// [sim/tb.sv]
// Self-checking testbench for the register map and wait/request block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rmwr_pkg::*;

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic cs, rd_en, wr_en, chan_sel, cmd_stb, cmd_chan;
  logic [DATA_W-1:0] din, dout, tx_data, irq_vector, master_irq_ctl, q, v;
  logic [1:0][15:0][DATA_W-1:0] rr = '0;
  logic [1:0] tx_full = 2'h3;
  logic [1:0] rx_avail = 2'h0;
  logic [1:0] sync_mode = 2'h0;
  logic [1:0] crc_end = 2'h0;
  logic [1:0] tx_load, rx_take, wreq_o, wreq_oe, dtr_req_o, crc_code;
  logic [2:0] cmd_code;
  logic [DATA_W-1:0] wb [2][16];
  logic [31:0] seed = 32'h9;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int nstb = 0;
  int exp_stb = 0;
  int nld = 0;
  int ntk = 0;
  int nlow;

  always #25 sys_clk = ~sys_clk;

  rmwr_top rmwr_top_inst (.sys_clk(sys_clk), .srst(srst), .cs(cs), .rd_en(rd_en), .wr_en(wr_en),
    .chan_sel(chan_sel), .din(din), .rr_image(rr), .tx_full(tx_full), .rx_avail(rx_avail),
    .sync_mode(sync_mode), .crc_end(crc_end), .dout(dout), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .crc_code(crc_code), .cmd_chan(cmd_chan), .tx_data(tx_data),
    .tx_load(tx_load), .rx_take(rx_take), .irq_vector(irq_vector),
    .master_irq_ctl(master_irq_ctl), .wreq_o(wreq_o), .wreq_oe(wreq_oe), .dtr_req_o(dtr_req_o));

  rmwr_host rmwr_host_inst (.sys_clk(sys_clk), .dout(dout), .wreq_o(wreq_o), .wreq_oe(wreq_oe),
    .cs(cs), .rd_en(rd_en), .wr_en(wr_en), .chan_sel(chan_sel), .din(din));

  // ------------------------------------------------------------
  // Pulse counters and run limit
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    nstb += int'(cmd_stb === 1'b1);
    nld += int'(tx_load[0] === 1'b1) + int'(tx_load[1] === 1'b1);
    ntk += int'(rx_take[0] === 1'b1) + int'(rx_take[1] === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] exp_rd(input int c, input int i, input logic fifo,
      input logic ext);
    if (ext && (i == 4 || i == 5)) return wb[c][i];
    if (i == 9) return ext ? wb[c][3] : rr[c][13];
    if (i == 11) return ext ? wb[c][10] : rr[c][15];
    if (ext && i == 14) return wb[c][7];
    if (i >= 4 && i < 8 && !(fifo && i >= 6)) return rr[c][i-4];
    return rr[c][i];
  endfunction : exp_rd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic acc(input int c, input int i, input logic wr, input logic [7:0] d);
    if (i != 0) begin
      exp_stb++;
      rmwr_host_inst.cyc(c[0], 1'b1, {4'h0, i[3:0]}, q);
    end
    exp_stb += int'(i == 0 && wr);
    rmwr_host_inst.cyc(c[0], wr, d, q);
    if (wr) wb[c][i] = d;
  endtask : acc

  // The output level is masked by the enable, since a floating pin has no defined level.
  task automatic pin(input int c, input logic [1:0] e);
    repeat (3) @(negedge sys_clk);
    chk({6'h00, wreq_oe[c], wreq_o[c] & wreq_oe[c]}, {6'h00, e});
  endtask : pin

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    chk({4'h0, wreq_oe, wreq_o}, 8'h03);
    chk({6'h00, dtr_req_o}, 8'h03);
    chk(dout, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 2; c++) begin
      v = rnd();
      acc(c, 2, 1'b1, v);
      chk(irq_vector, v);
      v = rnd();
      acc(c, 9, 1'b1, v);
      chk(master_irq_ctl, v);
      for (int i = 0; i < 8; i++) begin
        if (i != 1) begin
          acc(c, 0, 1'b1, {i[1:0], i[2:0], 3'h0});
          chk({2'h0, cmd_chan, cmd_code, crc_code}, {2'h0, c[0], i[2:0], i[1:0]});
        end
      end
      v = rnd();
      acc(c, 8, 1'b1, v);
      chk(tx_data, v);
      acc(c, 3, 1'b1, rnd());
      acc(c, 4, 1'b1, rnd());
      acc(c, 5, 1'b1, rnd());
      acc(c, 10, 1'b1, rnd());
    end
    $display("test shared and command registers done");
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 2; c++) begin
        acc(c, 15, 1'b1, {5'h00, m != 0, 2'h1});
        acc(c, 7, 1'b1, (m == 2) ? 8'h40 : 8'h00);
        for (int k = 0; k < 16; k++) rr[c][k] = rnd();
      end
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < 16; i++) begin
          acc(c, i, 1'b0, 8'h00);
          chk(q, exp_rd(c, i, m > 0, m == 2));
        end
      end
    end
    $display("test read map done");
    for (int c = 0; c < 2; c++) begin
      tx_full = 2'h3;
      acc(c, 1, 1'b1, 8'h40);
      pin(c, 2'h3);
      acc(c, 1, 1'b1, 8'h00);
      pin(c, 2'h0);
      acc(c, 1, 1'b1, 8'hC0);
      pin(c, 2'h3);
      tx_full[c] = 1'b0;
      pin(c, 2'h2);
      fork
        rmwr_host_inst.cyc(c[0], 1'b0, 8'h00, q);
        begin
          repeat (3) @(negedge sys_clk);
          chk({7'h00, wreq_o[c]}, 8'h01);
        end
      join
      pin(c, 2'h2);
      tx_full[c] = 1'b1;
      sync_mode[c] = 1'b1;
      pin(c, 2'h3);
      @(negedge sys_clk);
      crc_end[c] = 1'b1;
      nlow = 0;
      repeat (4) begin
        @(negedge sys_clk);
        crc_end[c] = 1'b0;
        nlow += int'(wreq_o[c] === 1'b0);
      end
      chk(nlow[7:0], 8'h01);
      sync_mode[c] = 1'b0;
      acc(c, 1, 1'b1, 8'hE0);
      rx_avail[c] = 1'b1;
      pin(c, 2'h2);
      rx_avail[c] = 1'b0;
      pin(c, 2'h3);
      tx_full[c] = 1'b0;
      acc(c, 1, 1'b1, 8'h80);
      pin(c, 2'h0);
      tx_full[c] = 1'b1;
      exp_stb++;
      rmwr_host_inst.cyc(c[0], 1'b1, 8'h08, q);
      fork
        rmwr_host_inst.cyc(c[0], 1'b1, rnd(), q);
        begin
          repeat (5) @(negedge sys_clk);
          chk({6'h00, wreq_oe[c], wreq_o[c]}, 8'h02);
          tx_full[c] = 1'b0;
        end
      join
      pin(c, 2'h0);
      acc(c, 1, 1'b1, 8'h00);
      acc(c, 14, 1'b1, 8'h04);
      repeat (3) @(negedge sys_clk);
      chk({7'h00, dtr_req_o[c]}, 8'h00);
      tx_full[c] = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({7'h00, dtr_req_o[c]}, 8'h01);
    end
    $display("test wait and request pins done");
    chk(nstb[7:0], exp_stb[7:0]);
    chk(nld[7:0], 8'h04);
    chk(ntk[7:0], 8'h06);
    $display("test pulse counts done");
    end_sim();
  end
endmodule : tb
